// >>> rtl/host_port_consts.svh
// constants for the host shared-memory and flags port
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ----------------------------------------------------------------------
// host address decode
// ----------------------------------------------------------------------
`define HP_ADDR_W        17
`define HP_ADDR_TOP      16
`define HP_ADDR_A2       2
`define HP_ADDR_A1       1
`define HP_ADDR_A0       0
`define HP_DATA_W        16
`define HP_WIN_W         16

// ----------------------------------------------------------------------
// flags register, local cpu address and layouts
// ----------------------------------------------------------------------
`define FLAGS_CPU_ADDR   32'hffa0_003c
`define FLAGS_RESET      8'h00
`define FLAGS_W          8
// normal layout
`define N_RST            7
`define N_H2C            6
`define N_SPARE          5
`define N_EN             4
`define N_SEL            3
`define N_IRQA           2
`define N_IRQB           1
`define N_CLR            0
// alternate layout
`define L_SPARE          5
`define L_RST            4
`define L_CLR            3
`define L_EN             2
`define L_IRQB           1
`define L_H2C            0

// ----------------------------------------------------------------------
// misc
// ----------------------------------------------------------------------
`define SYNC_BITS        35
`define SYNC_RESET       35'h7_ffff_ffff
`define ZERO_BYTE        8'h00
`define ZERO_WIN         16'h0000

`endif

// >>> rtl/host_port_pkg.sv
// types shared by the host port design files
package host_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REG,
    ST_MEM,
    ST_HOLD
  } port_state_e;

  typedef logic [7:0] flags_t;

endpackage : host_port_pkg

// >>> rtl/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int                  WIDTH     = 1,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  pin_in,
  output var  logic [WIDTH-1:0]  pin_sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          meta_q[i]       <= RESET_VAL[i];
          pin_sync_out[i] <= RESET_VAL[i];
        end
        else
        begin
          meta_q[i]       <= pin_in[i];
          pin_sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

`default_nettype wire

// >>> rtl/host_port.sv
// host port: shared memory window, flags register and host interrupts
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module host_port (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      host_reset_n,
  input  wire logic                      soft_reset,
  input  wire logic                      host_chip_select_n,
  input  wire logic                      host_read_write,
  input  wire logic [`HP_ADDR_W-1:0]     host_addr,
  input  wire logic [`HP_DATA_W-1:0]     host_data_in,
  output var  logic [`HP_DATA_W-1:0]     host_data_out,
  output var  logic                      host_data_oe,
  output var  logic                      host_ack_n,
  output var  logic                      xcvr_enable_n,
  output var  logic                      xcvr_direction,
  output var  logic                      host_irq_out1_n,
  output var  logic                      host_irq_out2_n,
  input  wire logic                      mode_shared,
  input  wire logic                      mode_fifo,
  input  wire logic                      port_16bit,
  input  wire logic                      alt_layout_sel,
  input  wire logic [31:0]               ram_base,
  output var  logic                      mem_req,
  output var  logic                      mem_we,
  output var  logic [31:0]               mem_addr,
  output var  logic [`HP_DATA_W-1:0]     mem_wdata,
  input  wire logic                      mem_ack,
  input  wire logic [`HP_DATA_W-1:0]     mem_rdata,
  input  wire logic                      cpu_flags_wr,
  input  wire host_port_pkg::flags_t     cpu_flags_wdata,
  output var  host_port_pkg::flags_t     cpu_flags_rdata,
  input  wire logic                      cpu_pending_clr,
  input  wire logic                      host_irq_cpu_enable_n,
  output var  logic                      host_irq_pending_n,
  output var  logic                      cpu_irq,
  input  wire logic                      cpu_pulse_irq,
  input  wire logic                      fifo_irq_status,
  output var  logic                      core_reset_req
);

  import host_port_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [`SYNC_BITS-1:0]   pins_raw;
  logic [`SYNC_BITS-1:0]   pins_s;
  logic                    cs_n_s;
  logic                    rd_s;
  logic [`HP_ADDR_W-1:0]   addr_s;
  logic [`HP_DATA_W-1:0]   data_s;

  // address and data are stable while select is low, so they ride along
  assign pins_raw = {host_chip_select_n, host_read_write, host_addr, host_data_in};

  pin_sync #(
    .WIDTH     (`SYNC_BITS),
    .RESET_VAL (`SYNC_RESET)
  ) u_sync (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pin_in       (pins_raw),
    .pin_sync_out (pins_s)
  );

  assign cs_n_s = pins_s[`SYNC_BITS-1];
  assign rd_s   = pins_s[`SYNC_BITS-2];
  assign addr_s = pins_s[`HP_ADDR_W+`HP_DATA_W-1:`HP_DATA_W];
  assign data_s = pins_s[`HP_DATA_W-1:0];

  // ----------------------------------------------------------------------
  // flags register view
  // ----------------------------------------------------------------------
  function automatic flags_t host_view(input flags_t f, input logic alt);
    flags_t v;
    logic   rst_rd;
    v      = `FLAGS_RESET;
    rst_rd = f[`N_RST] | f[`N_CLR];
    if (alt)
    begin
      v[`L_SPARE] = f[`N_SPARE];
      v[`L_RST]   = rst_rd;
      v[`L_CLR]   = f[`N_CLR];
      v[`L_EN]    = f[`N_EN];
      v[`L_IRQB]  = f[`N_IRQB];
      v[`L_H2C]   = f[`N_H2C];
    end
    else
    begin
      v           = f;
      v[`N_RST]   = rst_rd;
    end
    return v;
  endfunction : host_view

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  port_state_e state_q;
  port_state_e state_d;

  logic port_on;
  logic access_start;
  logic low_zero;
  logic sel_flags;
  logic sel_clr_cmd;
  logic sel_fixed;

  assign port_on      = mode_shared | mode_fifo;
  assign access_start = (state_q == ST_IDLE) & ~cs_n_s & port_on;
  assign low_zero     = ~addr_s[`HP_ADDR_A2] & ~addr_s[`HP_ADDR_A1];
  assign sel_flags    = addr_s[`HP_ADDR_TOP] & low_zero & ~addr_s[`HP_ADDR_A0];
  // shared mode ignores A2 and A1 for the clear command
  assign sel_clr_cmd  = addr_s[`HP_ADDR_TOP] & addr_s[`HP_ADDR_A0] &
                        (mode_shared | low_zero);
  // every A16 location answers with fixed timing, never a memory cycle
  assign sel_fixed    = addr_s[`HP_ADDR_TOP];

  // ----------------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (access_start)
        begin
          state_d = sel_fixed ? ST_REG : ST_MEM;
        end
      end
      ST_REG:
      begin
        state_d = ST_HOLD;
      end
      ST_MEM:
      begin
        if (mem_ack)
        begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (cs_n_s)
        begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // host handshake pins
  // ----------------------------------------------------------------------
  logic mem_done;
  logic reg_done;
  logic cycle_end;

  assign mem_done  = (state_q == ST_MEM) & mem_ack;
  assign reg_done  = (state_q == ST_REG);
  assign cycle_end = (state_q == ST_HOLD) & cs_n_s;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      host_ack_n     <= 1'b1;
      xcvr_enable_n  <= 1'b1;
      xcvr_direction <= 1'b0;
      host_data_oe   <= 1'b0;
    end
    else if (access_start)
    begin
      host_ack_n     <= 1'b0;
      xcvr_enable_n  <= 1'b0;
      xcvr_direction <= rd_s;
      host_data_oe   <= rd_s;
    end
    else if (mem_done | reg_done)
    begin
      host_ack_n     <= 1'b1;
    end
    else if (cycle_end)
    begin
      xcvr_enable_n  <= 1'b1;
      host_data_oe   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // memory window access
  // ----------------------------------------------------------------------
  logic [31:0] win_addr;

  assign win_addr = ram_base + {`ZERO_WIN, addr_s[`HP_WIN_W-1:0]};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end
    else if (access_start & ~sel_fixed)
    begin
      mem_req   <= 1'b1;
      mem_we    <= ~rd_s;
      mem_addr  <= win_addr;
      mem_wdata <= data_s;
    end
    else if (mem_done)
    begin
      mem_req   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // host write decode of the flags byte
  // ----------------------------------------------------------------------
  flags_t flags;
  flags_t wr_byte;
  logic   host_wr_flags;
  logic   host_clr_cmd;
  logic   w_rst;
  logic   w_h2c;
  logic   w_spare;
  logic   w_en;
  logic   w_sel;
  logic   w_clr;
  logic   clr_fall;
  logic   irq_clear;

  assign host_wr_flags = reg_done & sel_flags & ~rd_s;
  assign host_clr_cmd  = reg_done & sel_clr_cmd & ~rd_s;
  assign wr_byte = port_16bit ? data_s[`FLAGS_W-1:0]
                              : data_s[`HP_DATA_W-1:`FLAGS_W];

  assign w_rst   = alt_layout_sel ? wr_byte[`L_RST]   : wr_byte[`N_RST];
  assign w_h2c   = alt_layout_sel ? wr_byte[`L_H2C]   : wr_byte[`N_H2C];
  assign w_spare = alt_layout_sel ? wr_byte[`L_SPARE] : wr_byte[`N_SPARE];
  assign w_en    = alt_layout_sel ? wr_byte[`L_EN]    : wr_byte[`N_EN];
  // no sel bit in the alternate view, so it keeps its value there
  assign w_sel   = alt_layout_sel ? flags[`N_SEL]     : wr_byte[`N_SEL];
  assign w_clr   = alt_layout_sel ? wr_byte[`L_CLR]   : wr_byte[`N_CLR];

  // one then zero on the clear bit drops all three cpu interrupts: irq_a_q, irq_b_q and pulse_q
  assign clr_fall  = host_wr_flags & flags[`N_CLR] & ~w_clr;
  assign irq_clear = clr_fall | host_clr_cmd;

  // ----------------------------------------------------------------------
  // host-owned bits: reset only by the host reset pin; h2c is also cleared by cpu_pending_clr
  // ----------------------------------------------------------------------
  logic rst_req_q;
  logic h2c_q;
  logic spare_q;
  logic en_q;
  logic sel_q;
  logic clr_q;
  logic h2c_set;

  assign h2c_set = host_wr_flags & w_h2c;

  always_ff @(posedge clk_sys or negedge host_reset_n)
  begin
    if (!host_reset_n)
    begin
      rst_req_q <= 1'b0;
      h2c_q     <= 1'b0;
      spare_q   <= 1'b0;
      en_q      <= 1'b0;
      sel_q     <= 1'b0;
      clr_q     <= 1'b0;
    end
    else
    begin
      if (host_wr_flags)
      begin
        rst_req_q <= w_rst;
        spare_q   <= w_spare;
        en_q      <= w_en;
        sel_q     <= w_sel;
        clr_q     <= w_clr;
      end
      // set wins over the cpu clear in the same cycle
      h2c_q <= h2c_set | (h2c_q & ~cpu_pending_clr);
    end
  end

  // ----------------------------------------------------------------------
  // cpu-owned interrupt bits: cleared by local resets
  // ----------------------------------------------------------------------
  logic irq_a_q;
  logic irq_b_q;
  logic irq_a_d;
  logic irq_b_d;
  logic pulse_q;

  // a cpu set beats a host clear arriving in the same cycle
  assign irq_a_d = (cpu_flags_wr & cpu_flags_wdata[`N_IRQA]) |
                   (irq_a_q & ~irq_clear & ~cpu_flags_wr);
  assign irq_b_d = (cpu_flags_wr & cpu_flags_wdata[`N_IRQB]) |
                   (irq_b_q & ~irq_clear & ~cpu_flags_wr);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      pulse_q <= cpu_pulse_irq | (pulse_q & ~irq_clear);
    end
  end

  assign flags = {rst_req_q, h2c_q, spare_q, en_q, sel_q, irq_a_q, irq_b_q, clr_q};

  // ----------------------------------------------------------------------
  // host-to-cpu pending flag
  // ----------------------------------------------------------------------
  logic pending_d;

  assign pending_d = h2c_set | (~host_irq_pending_n & ~cpu_pending_clr);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      host_irq_pending_n <= 1'b1;
      cpu_irq            <= 1'b0;
    end
    else
    begin
      host_irq_pending_n <= ~pending_d;
      cpu_irq            <= pending_d & ~host_irq_cpu_enable_n;
    end
  end

  // ----------------------------------------------------------------------
  // host interrupt pins
  // ----------------------------------------------------------------------
  logic irq_cond;
  logic irq_live;

  assign irq_cond = irq_a_q | irq_b_q | pulse_q | fifo_irq_status;
  assign irq_live = irq_cond & en_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      host_irq_out1_n <= 1'b1;
      host_irq_out2_n <= 1'b1;
    end
    else
    begin
      host_irq_out1_n <= ~(irq_live & ~sel_q);
      host_irq_out2_n <= ~(irq_live & sel_q);
    end
  end

  // ----------------------------------------------------------------------
  // read data and reset request
  // ----------------------------------------------------------------------
  flags_t host_rd;

  assign host_rd = host_view(flags, alt_layout_sel);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      host_data_out   <= '0;
      cpu_flags_rdata <= `FLAGS_RESET;
      core_reset_req  <= 1'b0;
    end
    else
    begin
      if (reg_done & sel_flags & rd_s)
      begin
        host_data_out <= port_16bit ? {`ZERO_BYTE, host_rd}
                                    : {host_rd, `ZERO_BYTE};
      end
      else if (mem_done & ~mem_we)
      begin
        host_data_out <= mem_rdata;
      end
      cpu_flags_rdata <= flags;
      // host port and memory stay out of this reset
      core_reset_req  <= rst_req_q;
    end
  end

endmodule : host_port

`default_nettype wire

// >>> bench/host_port_monitor.sv
// concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module host_port_monitor (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  host_chip_select_n,
  input wire logic                  host_read_write,
  input wire logic [`HP_ADDR_W-1:0] host_addr,
  input wire logic                  host_ack_n,
  input wire logic                  host_data_oe,
  input wire logic                  xcvr_enable_n,
  input wire logic                  xcvr_direction,
  input wire logic [31:0]           ram_base,
  input wire logic                  mem_req,
  input wire logic                  mem_we,
  input wire logic [31:0]           mem_addr,
  input wire logic                  mem_ack,
  input wire logic                  cpu_pending_clr,
  input wire logic                  host_irq_cpu_enable_n,
  input wire logic                  host_irq_pending_n,
  input wire logic                  cpu_irq,
  input wire logic                  core_reset_req
);
  logic irq_cause;
  assign irq_cause = !host_irq_pending_n && !host_irq_cpu_enable_n && !cpu_pending_clr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // host handshake and memory side
  // ----------------------------------------------------------------------
  property p_sync_delay;
    $fell(host_chip_select_n) |-> host_ack_n [*2];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("ack before sync");
  property p_ack_start;
    $fell(host_ack_n) |-> !xcvr_enable_n && xcvr_direction == host_read_write
      && host_data_oe == host_read_write;
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("bad enable or dir");
  property p_mem_addr;
    $rose(mem_req) |-> mem_addr == ram_base + {16'h0000, host_addr[15:0]}
      && mem_we == !host_read_write;
  endproperty
  a_mem_addr: assert property (p_mem_addr) else $error("bad mem request");
  property p_ack_done;
    mem_req && mem_ack |=> host_ack_n;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack late");
  property p_en_hold;
    !xcvr_enable_n && !host_chip_select_n |=> !xcvr_enable_n;
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable dropped early");
  property p_en_end;
    $rose(xcvr_enable_n) |-> $past(host_chip_select_n, 2);
  endproperty
  a_en_end: assert property (p_en_end) else $error("enable ended with select low");

  // ----------------------------------------------------------------------
  // flag side effects
  // ----------------------------------------------------------------------
  property p_rst_req;
    $rose(core_reset_req) |-> !xcvr_enable_n && !host_read_write;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request w/o write");
  property p_cpu_irq;
    irq_cause |-> ##[1:2] cpu_irq;
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("cpu irq missing");
  property p_pend_clr;
    cpu_pending_clr |-> ##[1:2] host_irq_pending_n;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");

  c_mem_wr: cover property ($rose(mem_req) && mem_we);
  c_mem_rd: cover property ($rose(mem_req) && !mem_we);
  c_irq: cover property ($rose(cpu_irq));
endmodule : host_port_monitor
`default_nettype wire

// >>> bench/host_bus_model.sv
// external host processor model on the parallel port pins
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input  wire logic        clk_sys,
  output var  logic        host_chip_select_n,
  output var  logic        host_read_write,
  output var  logic [16:0] host_addr,
  output var  logic [15:0] host_data_in,
  input  wire logic        host_ack_n,
  input  wire logic [15:0] host_data_out
);
  initial
  begin
    host_chip_select_n = 1'b1;
    host_read_write = 1'b1;
    host_addr = 17'h0_0000;
    host_data_in = 16'h0000;
  end

  // released data lines show the inverse of the last value
  task automatic xfer(input logic rw, input logic [16:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
    int n;
    rd = 16'h0000;
    ok = 1'b0;
    n = 0;
    @(negedge clk_sys);
    host_addr = a;
    host_read_write = rw;
    host_data_in = rw ? ~host_data_in : wd;
    host_chip_select_n = 1'b0;
    while (host_ack_n !== 1'b0 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n < 40)
    begin
      ok = 1'b1;
      n = 0;
      while (host_ack_n !== 1'b1 && n < 400)
      begin
        @(negedge clk_sys);
        n++;
      end
      rd = host_data_out;
    end
    host_chip_select_n = 1'b1;
    host_data_in = ~host_data_in;
    repeat (8) @(negedge clk_sys);
  endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// >>> bench/tb_host_port.sv
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.svh"

module tb_host_port;
  import host_port_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, host_reset_n = 1'b0, soft_reset = 1'b0;
  logic host_chip_select_n, host_read_write, host_data_oe, host_ack_n;
  logic [16:0] host_addr;
  logic [15:0] host_data_in, host_data_out, mem_wdata, mem_rdata = 16'h0000, rd;
  logic xcvr_enable_n, xcvr_direction, host_irq_out1_n, host_irq_out2_n, mem_req, mem_we;
  logic mode_shared = 1'b1, mode_fifo = 1'b0, port_16bit = 1'b1, alt_layout_sel = 1'b0;
  logic [31:0] ram_base = 32'h0000_0000, mem_addr;
  logic mem_ack = 1'b0, cpu_flags_wr = 1'b0, cpu_pending_clr = 1'b0, ok, served = 1'b0;
  logic cpu_pulse_irq = 1'b0, fifo_irq_status = 1'b0, pls = 1'b0;
  logic host_irq_cpu_enable_n = 1'b1, host_irq_pending_n, cpu_irq, core_reset_req;
  flags_t cpu_flags_wdata = 8'h00, cpu_flags_rdata, fl, v;
  logic [15:0] mem [logic [31:0]];
  logic [15:0] a [8], d [8];
  int n_errors = 0, checks_done = 0, cycles = 0, lat = 0;

  host_port dut (.clk_sys, .rst, .host_reset_n, .soft_reset, .host_chip_select_n,
    .host_read_write, .host_addr, .host_data_in, .host_data_out, .host_data_oe, .host_ack_n,
    .xcvr_enable_n, .xcvr_direction, .host_irq_out1_n, .host_irq_out2_n, .mode_shared,
    .mode_fifo, .port_16bit, .alt_layout_sel, .ram_base, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .cpu_flags_wr, .cpu_flags_wdata, .cpu_flags_rdata,
    .cpu_pending_clr, .host_irq_cpu_enable_n, .host_irq_pending_n, .cpu_irq,
    .cpu_pulse_irq, .fifo_irq_status, .core_reset_req);
  host_bus_model host (.clk_sys, .host_chip_select_n, .host_read_write, .host_addr,
    .host_data_in, .host_ack_n, .host_data_out);

  always #20 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // memory responder with random latency
  // ----------------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (mem_req && !served && lat == 0)
    begin
      mem_ack = 1'b1;
      served = 1'b1;
      lat = $urandom_range(6);
      if (mem_we) mem[mem_addr] = mem_wdata;
      mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr[15:0];
    end
    else
    begin
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
      if (mem_req && !served) lat--;
      if (!mem_req) served = 1'b0;
    end
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------------
  function automatic flags_t view(flags_t n, logic alt);
    flags_t r;
    r = n;
    r[`N_RST] = n[`N_RST] | n[`N_CLR];
    if (alt) r = {2'b00, n[`N_SPARE], r[`N_RST], n[`N_CLR], n[`N_EN], n[`N_IRQB], n[`N_H2C]};
    return r;
  endfunction : view

  function automatic flags_t host_wr(flags_t f, flags_t w);
    flags_t r;
    r = {w[7], f[6] | w[6], w[5:3], f[2:1], w[0]};
    if (f[`N_CLR] && !w[`N_CLR]) r[2:1] = 2'b00;
    return r;
  endfunction : host_wr

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic flag_wr(input flags_t w);
    host.xfer(1'b0, 17'h1_0000, port_16bit ? {8'h00, w} : {w, 8'h00}, rd, ok);
    if (fl[`N_CLR] && !w[`N_CLR]) pls = 1'b0;
    fl = host_wr(fl, w);
  endtask : flag_wr

  task automatic cpu_set(input flags_t w);
    @(negedge clk_sys);
    cpu_flags_wdata = w;
    cpu_flags_wr = 1'b1;
    @(negedge clk_sys);
    cpu_flags_wr = 1'b0;
    fl[2:1] = w[2:1];
  endtask : cpu_set

  task automatic check_all;
    logic pend;
    host.xfer(1'b1, 17'h1_0000, 16'h0000, rd, ok);
    v = port_16bit ? rd[7:0] : rd[15:8];
    pend = (fl[2] | fl[1] | pls | fifo_irq_status) & fl[`N_EN];
    chk_word({8'h00, v & (alt_layout_sel ? 8'h3f : 8'hff)}, {8'h00, view(fl, alt_layout_sel)});
    chk_word({8'h00, cpu_flags_rdata}, {8'h00, fl});
    chk_bit(host_irq_out1_n, !(pend && !fl[`N_SEL]));
    chk_bit(host_irq_out2_n, !(pend && fl[`N_SEL]));
  endtask : check_all

  task automatic report_and_stop;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(90));
    ram_base = $urandom;
    fl = 8'h00;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    host_reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      a[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
      d[i] = 16'($urandom);
      host.xfer(1'b0, {1'b0, a[i]}, d[i], rd, ok);
      chk_word(mem[ram_base + {16'h0000, a[i]}], d[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      host.xfer(1'b1, {1'b0, a[i]}, 16'h0000, rd, ok);
      chk_word(rd, d[i]);
    end
    flag_wr(8'h31);
    check_all();
    flag_wr(8'h30);
    cpu_set(8'h04);
    check_all();
    flag_wr(8'h3e);
    check_all();
    host.xfer(1'b0, 17'h1_0007, 16'h0000, rd, ok);
    fl[2:1] = 2'b00;
    check_all();
    cpu_set(8'h06);
    flag_wr(8'h39);
    check_all();
    flag_wr(8'h38);
    check_all();
    cpu_set(8'h02);
    flag_wr(8'h28);
    check_all();
    cpu_pulse_irq = 1'b1;
    @(negedge clk_sys);
    cpu_pulse_irq = 1'b0;
    pls = 1'b1;
    cpu_set(8'h00);
    flag_wr(8'h39);
    check_all();
    flag_wr(8'h38);
    fifo_irq_status = 1'b1;
    check_all();
    fifo_irq_status = 1'b0;
    host_irq_cpu_enable_n = 1'b0;
    flag_wr(8'h70);
    chk_bit(host_irq_pending_n, 1'b0);
    chk_bit(cpu_irq, 1'b1);
    cpu_pending_clr = 1'b1;
    @(negedge clk_sys);
    cpu_pending_clr = 1'b0;
    fl[6] = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_bit(host_irq_pending_n, 1'b1);
    check_all();
    port_16bit = 1'b0;
    check_all();
    alt_layout_sel = 1'b1;
    check_all();
    host.xfer(1'b0, 17'h1_0000, 16'h0800, rd, ok);
    fl = (fl & 8'h4e) | 8'h01;
    check_all();
    {alt_layout_sel, mode_shared, mode_fifo} = 3'b001;
    check_all();
    mode_fifo = 1'b0;
    host.xfer(1'b1, 17'h1_0000, 16'h0000, rd, ok);
    chk_bit(ok, 1'b0);
    mode_shared = 1'b1;
    flag_wr(fl | 8'h80);
    chk_bit(core_reset_req, 1'b1);
    flag_wr(fl & 8'h7f);
    chk_bit(core_reset_req, 1'b0);
    cpu_set(8'h06);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    fl[2:1] = 2'b00;
    check_all();
    host_reset_n = 1'b0;
    @(negedge clk_sys);
    host_reset_n = 1'b1;
    fl = 8'h00;
    check_all();
    repeat (8)
    begin
      port_16bit = 1'($urandom);
      cpu_set(flags_t'($urandom) & 8'h06);
      flag_wr(flags_t'($urandom) & 8'h3f);
      check_all();
    end
    report_and_stop();
  end
endmodule : tb_host_port

bind host_port host_port_monitor mon (.clk_sys, .rst, .host_chip_select_n, .host_read_write,
  .host_addr, .host_ack_n, .host_data_oe, .xcvr_enable_n, .xcvr_direction, .ram_base,
  .mem_req, .mem_we, .mem_addr, .mem_ack, .cpu_pending_clr, .host_irq_cpu_enable_n,
  .host_irq_pending_n,
  .cpu_irq, .core_reset_req);
`default_nettype wire
